// >>> common/bbio_regs.vh
// Register map, mode codes and reset values of the bit-bang IO port
`ifndef BBIO_REGS_VH
`define BBIO_REGS_VH

// ==========================================================================
// Register addresses
`define BBIO_ADR_MODE     4'h0
`define BBIO_ADR_DIR      4'h1
`define BBIO_ADR_BAUD_LO  4'h2
`define BBIO_ADR_BAUD_HI  4'h3
`define BBIO_ADR_TXD      4'h4
`define BBIO_ADR_RXD      4'h5
`define BBIO_ADR_STAT     4'h6

// ==========================================================================
// Bit mode command codes
`define BBIO_MODE_RESET   8'h00
`define BBIO_MODE_ASYNC   8'h01
`define BBIO_MODE_SYNC    8'h04

// ==========================================================================
// Reset values
`define BBIO_BYTE_RST     8'h00
`define BBIO_BAUD_RST     16'h0018
`define BBIO_CNT_RST      16'h0000
`define BBIO_SEQ_RST      3'h0

// ==========================================================================
// Status register bit positions
`define BBIO_ST_TXFULL    0
`define BBIO_ST_RXVALID   1
`define BBIO_ST_BUSY      2
`define BBIO_ST_DROP      3
`define BBIO_ST_SYNC      4
`define BBIO_ST_ASYNC     5

`endif

// >>> core/bbio_baud.v
// Baud rate tick generator: one-cycle enable every divisor plus one clocks
`timescale 1ns/100ps
`default_nettype none
`include "bbio_regs.vh"

module bbio_baud (
  input  wire        clk_sys_i,
  input  wire        reset_i,
  input  wire        run_i,
  input  wire [15:0] div_i,
  output reg         tick_o
);

  reg [15:0] cnt_q;

  // ========================================================================
  // Divider
  // Held at zero while stopped so a new mode starts with a full period
  always @(posedge clk_sys_i) begin
    if (reset_i || !run_i) begin
      cnt_q  <= `BBIO_CNT_RST;
      tick_o <= 1'b0;
    end else if (cnt_q >= div_i) begin
      cnt_q  <= `BBIO_CNT_RST;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 16'h0001;
      tick_o <= 1'b0;
    end
  end

endmodule // bbio_baud
`default_nettype wire

// >>> core/bbio_pins.v
// Per-pin output latch and direction control of the eight port lines
`timescale 1ns/100ps
`default_nettype none
`include "bbio_regs.vh"

module bbio_pins (
  input  wire       clk_sys_i,
  input  wire       reset_i,
  input  wire       clear_i,
  input  wire       load_i,
  input  wire       en_i,
  input  wire [7:0] data_i,
  input  wire [7:0] dir_i,
  output wire [7:0] pin_o,
  output wire [7:0] pin_oe_n_o
);

  reg [7:0] out_q;
  reg [7:0] oe_n_q;

  // ========================================================================
  // One cell per line
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_cell
      always @(posedge clk_sys_i) begin
        if (reset_i || clear_i) begin
          out_q[gi]  <= 1'b0;
          oe_n_q[gi] <= 1'b1;
        end else begin
          // Latched value is held until the next load
          if (load_i) begin
            out_q[gi] <= data_i[gi];
          end
          oe_n_q[gi] <= ~(en_i & dir_i[gi]);
        end
      end
    end
  endgenerate

  assign pin_o      = out_q;
  assign pin_oe_n_o = oe_n_q;

endmodule // bbio_pins
`default_nettype wire

// >>> core/bbio_port.v
// Bit-bang IO port channel: register slave, mode control and access sequencer
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "bbio_regs.vh"

module bbio_port (
  input  wire       clk_sys_i,
  input  wire       reset_i,
  input  wire [3:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  input  wire [7:0] pin_i,
  output wire [7:0] pin_o,
  output wire [7:0] pin_oe_n_o,
  output reg        rd_n_o,
  output reg        wr_n_o
);

  // ========================================================================
  // Sequencer states
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_SAMPLE = 3'h1;
  localparam [2:0] ST_RDOFF  = 3'h2;
  localparam [2:0] ST_DRIVE  = 3'h3;
  localparam [2:0] ST_SETUP  = 3'h4;
  localparam [2:0] ST_WRLO   = 3'h5;
  localparam [2:0] ST_WRHI   = 3'h6;

  // ========================================================================
  // State
  reg  [7:0]  mode_q;
  reg  [7:0]  dir_q;
  reg  [15:0] baud_q;
  reg  [7:0]  txd_q;
  reg         tx_full_q;
  reg         tx_full_d;
  reg  [7:0]  rxd_q;
  reg         rx_valid_q;
  reg         rx_valid_d;
  reg         drop_q;
  reg         drop_d;
  reg  [2:0]  st_q;
  reg  [2:0]  st_d;
  reg  [7:0]  rd_word;

  wire        tick;
  wire        is_async;
  wire        is_sync;
  wire        active;
  wire        mode_wr;
  wire        mode_ok;
  wire        chan_clear;
  wire        txd_wr;
  wire        rxd_rd;
  wire        stat_wr;
  wire        start_async;
  wire        start_sync;
  wire        load_pins;
  wire        take_sample;

  assign is_async   = (mode_q == `BBIO_MODE_ASYNC);
  assign is_sync    = (mode_q == `BBIO_MODE_SYNC);
  assign active     = is_async | is_sync;
  assign mode_wr    = wr_i && (addr_i == `BBIO_ADR_MODE);
  assign mode_ok    = (wdata_i == `BBIO_MODE_RESET) || (wdata_i == `BBIO_MODE_ASYNC) ||
                      (wdata_i == `BBIO_MODE_SYNC);
  // Any accepted mode command aborts a running access and restarts pacing
  assign chan_clear = mode_wr && mode_ok;
  assign txd_wr     = wr_i && (addr_i == `BBIO_ADR_TXD);
  assign rxd_rd     = rd_i && (addr_i == `BBIO_ADR_RXD);
  assign stat_wr    = wr_i && (addr_i == `BBIO_ADR_STAT);

  // ========================================================================
  // Access start conditions
  assign start_async = (st_q == ST_IDLE) && is_async && tx_full_q && tick;
  // A held sample blocks the next byte until software has read it
  assign start_sync  = (st_q == ST_IDLE) && is_sync && tx_full_q && !rx_valid_q && tick;
  assign take_sample = start_sync;
  assign load_pins   = start_async || ((st_q == ST_RDOFF) && tick);

  // ========================================================================
  // Baud pacing: every phase of an access lasts one baud period
  bbio_baud u_baud (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .run_i     (active && !chan_clear),
    .div_i     (baud_q),
    .tick_o    (tick)
  );

  // ========================================================================
  // Pin drivers
  bbio_pins u_pins (
    .clk_sys_i  (clk_sys_i),
    .reset_i    (reset_i),
    .clear_i    (mode_wr && (wdata_i == `BBIO_MODE_RESET)),
    .load_i     (load_pins),
    .en_i       (active),
    .data_i     (txd_q),
    .dir_i      (dir_q),
    .pin_o      (pin_o),
    .pin_oe_n_o (pin_oe_n_o)
  );

  // ========================================================================
  // Mode and configuration registers
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      mode_q <= `BBIO_MODE_RESET;
      dir_q  <= `BBIO_BYTE_RST;
      baud_q <= `BBIO_BAUD_RST;
    end else if (chan_clear && (wdata_i == `BBIO_MODE_RESET)) begin
      mode_q <= `BBIO_MODE_RESET;
      dir_q  <= `BBIO_BYTE_RST;
      baud_q <= `BBIO_BAUD_RST;
    end else begin
      // Unknown mode codes are ignored and leave the mode unchanged
      if (chan_clear) begin
        mode_q <= wdata_i;
      end
      if (wr_i && (addr_i == `BBIO_ADR_DIR)) begin
        dir_q <= wdata_i;
      end
      if (wr_i && (addr_i == `BBIO_ADR_BAUD_LO)) begin
        baud_q[7:0] <= wdata_i;
      end
      if (wr_i && (addr_i == `BBIO_ADR_BAUD_HI)) begin
        baud_q[15:8] <= wdata_i;
      end
    end
  end

  // ========================================================================
  // Transmit holding byte
  always @* begin
    tx_full_d = tx_full_q;
    if (load_pins) begin
      tx_full_d = 1'b0;
    end
    // A byte is only accepted while a mode is active and the holder is free
    if (txd_wr && active && !tx_full_q) begin
      tx_full_d = 1'b1;
    end
  end

  // Refused writes are flagged; a new refusal wins over a clear
  always @* begin
    drop_d = drop_q;
    if (stat_wr && wdata_i[`BBIO_ST_DROP]) begin
      drop_d = 1'b0;
    end
    if (txd_wr && (!active || tx_full_q)) begin
      drop_d = 1'b1;
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i || (chan_clear && (wdata_i == `BBIO_MODE_RESET))) begin
      txd_q     <= `BBIO_BYTE_RST;
      tx_full_q <= 1'b0;
      drop_q    <= 1'b0;
    end else begin
      if (txd_wr && active && !tx_full_q) begin
        txd_q <= wdata_i;
      end
      tx_full_q <= chan_clear ? 1'b0 : tx_full_d;
      drop_q    <= drop_d;
    end
  end

  // ========================================================================
  // Receive buffer of one byte: sample wins over a read in the same cycle
  always @* begin
    rx_valid_d = rx_valid_q;
    if (rxd_rd) begin
      rx_valid_d = 1'b0;
    end
    if (take_sample) begin
      rx_valid_d = 1'b1;
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i || (chan_clear && (wdata_i == `BBIO_MODE_RESET))) begin
      rxd_q      <= `BBIO_BYTE_RST;
      rx_valid_q <= 1'b0;
    end else begin
      if (take_sample) begin
        rxd_q <= pin_i;
      end
      rx_valid_q <= rx_valid_d;
    end
  end

  // ========================================================================
  // Access sequencer
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (start_sync) begin
          st_d = ST_SAMPLE;
        end else if (start_async) begin
          st_d = ST_SETUP;
        end
      end
      ST_SAMPLE: begin
        if (tick) begin
          st_d = ST_RDOFF;
        end
      end
      ST_RDOFF: begin
        if (tick) begin
          st_d = ST_DRIVE;
        end
      end
      ST_DRIVE: begin
        if (tick) begin
          st_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (tick) begin
          st_d = ST_WRLO;
        end
      end
      ST_WRLO: begin
        if (tick) begin
          st_d = ST_WRHI;
        end
      end
      ST_WRHI: begin
        if (tick) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (reset_i || chan_clear) begin
      st_q <= `BBIO_SEQ_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ========================================================================
  // Strobes, registered from the next state so they line up with the pins
  always @(posedge clk_sys_i) begin
    if (reset_i || chan_clear) begin
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
    end else begin
      rd_n_o <= !((st_d == ST_SAMPLE) || (st_d == ST_DRIVE));
      wr_n_o <= !(st_d == ST_WRLO);
    end
  end

  // ========================================================================
  // Register read port: data valid only in the cycle after the strobe
  always @* begin
    rd_word = `BBIO_BYTE_RST;
    case (addr_i)
      `BBIO_ADR_MODE:    rd_word = mode_q;
      `BBIO_ADR_DIR:     rd_word = dir_q;
      `BBIO_ADR_BAUD_LO: rd_word = baud_q[7:0];
      `BBIO_ADR_BAUD_HI: rd_word = baud_q[15:8];
      `BBIO_ADR_TXD:     rd_word = txd_q;
      `BBIO_ADR_RXD:     rd_word = rxd_q;
      `BBIO_ADR_STAT: begin
        rd_word[`BBIO_ST_TXFULL]  = tx_full_q;
        rd_word[`BBIO_ST_RXVALID] = rx_valid_q;
        rd_word[`BBIO_ST_BUSY]    = (st_q != ST_IDLE);
        rd_word[`BBIO_ST_DROP]    = drop_q;
        rd_word[`BBIO_ST_SYNC]    = is_sync;
        rd_word[`BBIO_ST_ASYNC]   = is_async;
      end
      default:           rd_word = `BBIO_BYTE_RST;
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_o <= `BBIO_BYTE_RST;
    end else if (rd_i) begin
      rdata_o <= rd_word;
    end else begin
      rdata_o <= `BBIO_BYTE_RST;
    end
  end

endmodule // bbio_port
`default_nettype wire

// >>> verif/bbio_ext_model.sv
// External logic clocked by the port's write strobe
`timescale 1ns/100ps
`default_nettype none
module bbio_ext_model (
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe_n_o,
  input  wire logic       wr_n_o,
  input  wire logic [7:0] ext_i,
  output logic      [7:0] pin_i,
  output logic      [7:0] latch_o,
  output logic      [7:0] wr_cnt_o
);
  // Lines the port does not drive carry the external value
  assign pin_i = (pin_o & ~pin_oe_n_o) | (ext_i & pin_oe_n_o);
  initial begin
    latch_o  = 8'h00;
    wr_cnt_o = 8'h00;
  end
  // Captures the bus on the trailing edge of the write strobe
  always @(posedge wr_n_o) begin
    latch_o  <= pin_i;
    wr_cnt_o <= wr_cnt_o + 8'h01;
  end
endmodule // bbio_ext_model
`default_nettype wire

// >>> verif/bbio_port_monitor.sv
// Concurrent checks on the ports of the bit-bang IO port
`timescale 1ns/100ps
`default_nettype none
module bbio_port_monitor (
  input wire logic       clk_sys_i,
  input wire logic       reset_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] pin_i,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_n_o,
  input wire logic       rd_n_o,
  input wire logic       wr_n_o
);
  // ======================================
  // Shadow of mode, direction, queued byte
  logic [7:0] mode_q;
  logic [7:0] dir_q;
  logic       pend_q;
  logic [1:0] age_q;
  wire logic  mwr  = wr_i && addr_i == 4'h0;
  wire logic  dwr  = wr_i && addr_i == 4'h1;
  wire logic  mact = mode_q != 8'h00;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || (mwr && wdata_i == 8'h00)) begin
      mode_q <= 8'h00;
      dir_q  <= 8'h00;
      pend_q <= 1'b0;
      age_q  <= 2'h0;
    end else begin
      if (mwr && (wdata_i == 8'h01 || wdata_i == 8'h04)) mode_q <= wdata_i;
      if (dwr) dir_q <= wdata_i;
      if (mwr || dwr) age_q <= 2'h0;
      else if (age_q != 2'h3) age_q <= age_q + 2'h1;
      // Set wins so a byte queued as the last one loads is not forgotten
      if (wr_i && addr_i == 4'h4 && mact) pend_q <= 1'b1;
      else if ($changed(pin_o)) pend_q <= 1'b0;
    end
  end
  // ======================================
  // Properties
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  sequence s_load;
    $changed(pin_o) && mact && $past(mode_q) != 8'h00;
  endsequence
  sequence s_wr_low;
    // A mode write within 1000 cycles of the load aborts the access legally
    ##[0:1000] (!wr_n_o || mwr);
  endsequence
  AST_CLR: assert property (
    mwr && wdata_i == 8'h00 |-> ##2 (rd_n_o && wr_n_o && pin_o == 8'h00 && pin_oe_n_o == 8'hff))
    else $error("channel reset left strobes or pins active");
  AST_OE: assert property (
    age_q == 2'h3 |-> pin_oe_n_o == (mact ? ~dir_q : 8'hff))
    else $error("output enables do not follow direction");
  AST_ASYNC_RD: assert property (
    mode_q == 8'h01 && $past(mode_q) == 8'h01 |-> rd_n_o)
    else $error("read strobe active in async mode");
  AST_PIN_CAUSE: assert property (
    s_load |-> $past(pend_q))
    else $error("pins changed with no byte queued");
  AST_LOAD_SETUP: assert property (
    s_load |-> wr_n_o)
    else $error("write strobe low as pins change");
  AST_LOAD_WR: assert property (
    s_load |-> s_wr_low)
    else $error("no write strobe after pins changed");
  AST_SYNC_DRIVE: assert property (
    mode_q == 8'h04 && $past(mode_q) == 8'h04 && $changed(pin_o) |-> $fell(rd_n_o))
    else $error("sync drive without read strobe reassertion");
  AST_WR_STEADY: assert property (
    !wr_n_o && mact |-> $stable(pin_o))
    else $error("pins moved under write strobe");
  AST_RD_IDLE: assert property (
    !$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read cycle");
endmodule // bbio_port_monitor
bind bbio_port bbio_port_monitor u_mon (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o),
  .pin_oe_n_o(pin_oe_n_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o));
`default_nettype wire

// >>> verif/bbio_port_tb.sv
// Self-checking testbench of the bit-bang IO port
`timescale 1ns/100ps
`default_nettype none
`include "bbio_regs.vh"
module bbio_port_tb;
  logic       clk_sys_i, reset_i, wr_i, rd_i, rd_n_o, wr_n_o;
  logic [3:0] addr_i;
  logic [7:0] wdata_i, rdata_o, pin_i, pin_o, pin_oe_n_o, ext_q, latch, wcnt;
  logic [7:0] rv, b, x, dir, e, prev, c, dv;
  logic [7:0] lc = 8'h00;
  logic [7:0] wlen = 8'h00;
  int         mismatches, checks_done, seed, n;
  bbio_port DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_n_o(pin_oe_n_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o));
  bbio_ext_model u_ext (.pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .wr_n_o(wr_n_o), .ext_i(ext_q),
    .pin_i(pin_i), .latch_o(latch), .wr_cnt_o(wcnt));
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // Length of the last write strobe pulse in clocks
  always @(posedge clk_sys_i) begin
    if (!wr_n_o) lc <= lc + 8'h01;
    else if (lc != 8'h00) begin
      wlen <= lc;
      lc   <= 8'h00;
    end
  end
  // ======================================
  // Bus tasks and checks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Waits for the external logic to see one more write strobe
  task automatic wait_wr(input logic [7:0] c0);
    n = 0;
    while (wcnt === c0 && n < 3000) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 3000) begin
      mismatches++;
      $display("[ERR] %0t no write strobe", $time);
      finish_test();
    end else begin
      repeat (2) @(posedge clk_sys_i);
    end
  endtask
  // Expected bus level: own drive on outputs, external value on inputs
  function automatic logic [7:0] bus(input logic [7:0] d, input logic [7:0] m, input logic [7:0] v);
    return (d & m) | (v & ~m);
  endfunction
  // ======================================
  // Main sequence
  initial begin
    seed = 72;
    mismatches = 0;
    checks_done = 0;
    reset_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    ext_q = 8'h3c;
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd(`BBIO_ADR_BAUD_LO, rv);
    chk(rv, 8'h18);
    rd(4'hf, rv);
    chk(rv, 8'h00);
    chk({6'h00, rd_n_o, wr_n_o}, 8'h03);
    wr(`BBIO_ADR_TXD, 8'ha5);
    rd(`BBIO_ADR_STAT, rv);
    chk(rv & 8'h08, 8'h08);
    // Drop flag is write-one-to-clear
    wr(`BBIO_ADR_STAT, 8'h08);
    rd(`BBIO_ADR_STAT, rv);
    chk(rv & 8'h08, 8'h00);
    wr(`BBIO_ADR_MODE, 8'h02);
    rd(`BBIO_ADR_MODE, rv);
    chk(rv, 8'h00);
    chk(pin_oe_n_o, 8'hff);
    $display("test reset done");
    wr(`BBIO_ADR_MODE, `BBIO_MODE_ASYNC);
    for (int i = 0; i < 6; i++) begin
      dir = $random(seed);
      dv = 8'd25 + ($random(seed) & 3);
      b = $random(seed);
      e = $random(seed);
      ext_q <= e;
      wr(`BBIO_ADR_DIR, dir);
      wr(`BBIO_ADR_BAUD_LO, dv);
      wr(`BBIO_ADR_BAUD_HI, 8'h00);
      c = wcnt;
      wr(`BBIO_ADR_TXD, b);
      wait_wr(c);
      chk(pin_o, b);
      chk(latch, bus(b, dir, e));
      chk(pin_oe_n_o, ~dir);
      chk(wlen, dv + 8'd1);
      repeat (40) @(posedge clk_sys_i);
      chk(pin_o, b);
    end
    $display("test async done");
    prev = b;
    dir = $random(seed);
    wr(`BBIO_ADR_DIR, dir);
    wr(`BBIO_ADR_BAUD_LO, 8'h00);
    wr(`BBIO_ADR_MODE, `BBIO_MODE_SYNC);
    for (int i = 0; i < 7; i++) begin
      if (i < 6) b = $random(seed);
      e = $random(seed);
      ext_q <= e;
      c = wcnt;
      wr(`BBIO_ADR_TXD, b);
      wait_wr(c);
      rd(`BBIO_ADR_RXD, rv);
      chk(rv, bus(prev, dir, e));
      chk(pin_o, b);
      prev = b;
    end
    x = $random(seed);
    c = wcnt;
    wr(`BBIO_ADR_TXD, x);
    wait_wr(c);
    wr(`BBIO_ADR_TXD, ~x);
    repeat (60) @(posedge clk_sys_i);
    chk(pin_o, x);
    rd(`BBIO_ADR_STAT, rv);
    chk(rv & 8'h17, 8'h13);
    c = wcnt;
    rd(`BBIO_ADR_RXD, rv);
    chk(rv, bus(prev, dir, e));
    wait_wr(c);
    chk(pin_o, ~x);
    rd(`BBIO_ADR_RXD, rv);
    chk(rv, bus(x, dir, e));
    $display("test sync done");
    wr(`BBIO_ADR_TXD, 8'h5a);
    n = 0;
    while (rd_n_o !== 1'b0 && n < 200) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 200) begin
      mismatches++;
      $display("[ERR] %0t no read strobe", $time);
      finish_test();
    end
    wr(`BBIO_ADR_MODE, `BBIO_MODE_RESET);
    repeat (2) @(posedge clk_sys_i);
    chk({6'h00, rd_n_o, wr_n_o}, 8'h03);
    chk(pin_o, 8'h00);
    chk(pin_oe_n_o, 8'hff);
    rd(`BBIO_ADR_DIR, rv);
    chk(rv, 8'h00);
    rd(`BBIO_ADR_BAUD_LO, rv);
    chk(rv, 8'h18);
    $display("test abort done");
    finish_test();
  end
endmodule // bbio_port_tb
`default_nettype wire
